// file: verilog/power_supervisor_defs.svh
// Timing constants and counter widths of the pushbutton power supervisor.
// Assumes a 100 MHz system clock; counts derive from times by integer expressions.
`ifndef POWER_SUPERVISOR_DEFS_SVH
`define POWER_SUPERVISOR_DEFS_SVH

`define CLK_PERIOD_NS 10
`define DEBOUNCE_TIME_MS 26
`define RESET_TIME_MS 200
`define WATCHDOG_TIME_MS 1600
`define BLANKING_TIME_MS 500
`define MS_CYCLES(ms) ((ms) * 1000000 / `CLK_PERIOD_NS)
`define DEBOUNCE_CYCLES `MS_CYCLES(`DEBOUNCE_TIME_MS)
`define RESET_CYCLES `MS_CYCLES(`RESET_TIME_MS)
`define WATCHDOG_CYCLES `MS_CYCLES(`WATCHDOG_TIME_MS)
`define BLANKING_CYCLES `MS_CYCLES(`BLANKING_TIME_MS)
`define COUNT_WIDTH 32
`define EXTRA_WIDTH 32

`endif

// file: verilog/power_supervisor_pkg.sv
// Types shared by the pushbutton power supervisor design files.
// Assumes nothing beyond the defs header widths.
`include "power_supervisor_defs.svh"
package power_supervisor_pkg;

    typedef enum logic [2:0] {
        BTN_IDLE,
        BTN_FIXED,
        BTN_EXTRA,
        BTN_RELEASE
    } button_state_type;

    typedef enum logic [1:0] {
        WD_HOLD,
        WD_RELEASE,
        WD_RUN,
        WD_PULSE
    } reset_state_type;

    typedef struct packed {
        logic button_n;
        logic select_a;
        logic select_b;
        logic supply_sense;
        logic heartbeat_in;
        logic heartbeat_float;
        logic early_warn_in;
        logic kill_n;
    } pin_bundle_type;

endpackage : power_supervisor_pkg

// file: verilog/pin_sync.sv
// Three-stage input synchroniser with agreement filter for asynchronous pins.
// Assumes pins are asynchronous to i_sys_clk; output changes when stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_pins
);
    timeunit 1ns / 1ps;

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= i_pins;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pins <= RESET_VALUE;
        end else begin
            o_pins <= (stage2 & stage3) | (o_pins & (stage2 ^ stage3));
        end
    end

endmodule : pin_sync

// file: verilog/reset_watchdog.sv
// Voltage-monitor reset generator with heartbeat watchdog.
// Assumes synchronised inputs on i_sys_clk.
`include "power_supervisor_defs.svh"
module reset_watchdog #(
    parameter int RESET_CYCLES = `RESET_CYCLES,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_supply_sense,
    input wire logic i_heartbeat_in,
    input wire logic i_heartbeat_float,
    output logic o_sys_reset_n
);
    timeunit 1ns / 1ps;

    power_supervisor_pkg::reset_state_type state;
    logic [`COUNT_WIDTH-1:0] count;
    logic heartbeat_prev;
    logic heartbeat_edge;

    assign heartbeat_edge = i_heartbeat_in ^ heartbeat_prev;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            heartbeat_prev <= 1'b0;
        end else begin
            heartbeat_prev <= i_heartbeat_in;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= power_supervisor_pkg::WD_HOLD;
            count <= '0;
        end else if (!i_supply_sense) begin
            state <= power_supervisor_pkg::WD_HOLD;
            count <= '0;
        end else begin
            case (state)
                power_supervisor_pkg::WD_HOLD: begin
                    if (count >= `COUNT_WIDTH'(RESET_CYCLES - 1)) begin
                        state <= power_supervisor_pkg::WD_RUN;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                power_supervisor_pkg::WD_RUN, power_supervisor_pkg::WD_RELEASE: begin
                    if (i_heartbeat_float || heartbeat_edge) begin
                        state <= power_supervisor_pkg::WD_RUN;
                        count <= '0;
                    end else if (count >= `COUNT_WIDTH'(WATCHDOG_CYCLES - 1)) begin
                        state <= power_supervisor_pkg::WD_PULSE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                power_supervisor_pkg::WD_PULSE: begin
                    if (i_heartbeat_float || heartbeat_edge) begin
                        state <= power_supervisor_pkg::WD_RUN;
                        count <= '0;
                    end else if (count >= `COUNT_WIDTH'(RESET_CYCLES - 1)) begin
                        state <= power_supervisor_pkg::WD_RELEASE;
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                default: begin
                    state <= power_supervisor_pkg::WD_HOLD;
                    count <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sys_reset_n <= 1'b0;
        end else begin
            o_sys_reset_n <= i_supply_sense && (state == power_supervisor_pkg::WD_RUN ||
                             state == power_supervisor_pkg::WD_RELEASE);
        end
    end

endmodule : reset_watchdog

// file: verilog/pushbutton_power_supervisor.sv
// Pushbutton on/off controller: debounce, mode pins, diode/converter enables, host alert, monitors.
// Assumes all pins asynchronous; open-drain outputs given as output enables, high while pulling low.
`include "power_supervisor_defs.svh"
module pushbutton_power_supervisor #(
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
    parameter int RESET_CYCLES = `RESET_CYCLES,
    parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES,
    parameter int BLANKING_CYCLES = `BLANKING_CYCLES,
    parameter int SHUTDOWN_CYCLES = 1000
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_button_in_n,
    input wire logic i_select_a,
    input wire logic i_select_b,
    input wire logic i_supply_sense,
    input wire logic i_heartbeat_in,
    input wire logic i_heartbeat_float,
    input wire logic i_early_warn_in,
    input wire logic i_kill_n,
    input wire logic [`EXTRA_WIDTH-1:0] i_turn_on_extra_delay,
    input wire logic [`EXTRA_WIDTH-1:0] i_shutdown_extra_delay,
    output logic o_diode_primary_en,
    output logic o_diode_secondary_en,
    output logic o_converter_en_oe,
    output logic o_host_alert_n_oe,
    output logic o_early_warn_out_n_oe,
    output logic o_sys_reset_n_oe,
    output logic o_power_on
);
    timeunit 1ns / 1ps;

    // ****************************************
    // Input synchronisation
    // ****************************************
    power_supervisor_pkg::pin_bundle_type raw_pins;
    power_supervisor_pkg::pin_bundle_type pins;
    logic sys_reset_n;

    assign raw_pins = '{button_n: i_button_in_n, select_a: i_select_a, select_b: i_select_b,
                        supply_sense: i_supply_sense, heartbeat_in: i_heartbeat_in,
                        heartbeat_float: i_heartbeat_float, early_warn_in: i_early_warn_in,
                        kill_n: i_kill_n};

    pin_sync #(
        .WIDTH(8),
        .RESET_VALUE(8'hE1)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_pins(raw_pins),
        .o_pins(pins)
    );

    // ****************************************
    // Pushbutton debounce
    // ****************************************
    power_supervisor_pkg::button_state_type btn_state;
    logic [`COUNT_WIDTH-1:0] btn_count;
    logic power_state;
    logic push_on;
    logic push_off;
    logic alert_push;
    logic in_shutdown;
    logic [`COUNT_WIDTH-1:0] shut_count;
    logic select_b_prev;
    logic digital_on;
    logic digital_off;

    function automatic logic reached(input logic [`COUNT_WIDTH-1:0] count, input int limit);
        reached = count >= `COUNT_WIDTH'(limit - 1);
    endfunction : reached

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            btn_state <= power_supervisor_pkg::BTN_IDLE;
            btn_count <= '0;
        end else begin
            case (btn_state)
                power_supervisor_pkg::BTN_IDLE: begin
                    btn_count <= '0;
                    if (!pins.button_n && !in_shutdown) begin
                        btn_state <= power_supervisor_pkg::BTN_FIXED;
                    end
                end
                power_supervisor_pkg::BTN_FIXED: begin
                    if (pins.button_n) begin
                        btn_state <= power_supervisor_pkg::BTN_IDLE;
                    end else if (reached(btn_count, DEBOUNCE_CYCLES)) begin
                        btn_state <= power_supervisor_pkg::BTN_EXTRA;
                        btn_count <= '0;
                    end else begin
                        btn_count <= btn_count + 1'b1;
                    end
                end
                power_supervisor_pkg::BTN_EXTRA: begin
                    if (pins.button_n) begin
                        btn_state <= power_supervisor_pkg::BTN_IDLE;
                    end else if (btn_count >= (power_state ? i_shutdown_extra_delay
                                                           : i_turn_on_extra_delay)) begin
                        btn_state <= power_supervisor_pkg::BTN_RELEASE;
                        btn_count <= '0;
                    end else begin
                        btn_count <= btn_count + 1'b1;
                    end
                end
                power_supervisor_pkg::BTN_RELEASE: begin
                    if (!pins.button_n) begin
                        btn_count <= '0;
                    end else if (reached(btn_count, DEBOUNCE_CYCLES)) begin
                        btn_state <= power_supervisor_pkg::BTN_IDLE;
                        btn_count <= '0;
                    end else begin
                        btn_count <= btn_count + 1'b1;
                    end
                end
                default: begin
                    btn_state <= power_supervisor_pkg::BTN_IDLE;
                    btn_count <= '0;
                end
            endcase
        end
    end

    // Valid push ends the extra delay with button still down
    assign push_on = btn_state == power_supervisor_pkg::BTN_EXTRA && !pins.button_n && !power_state &&
                     btn_count >= i_turn_on_extra_delay;
    assign push_off = btn_state == power_supervisor_pkg::BTN_EXTRA && !pins.button_n && power_state &&
                      btn_count >= i_shutdown_extra_delay;
    assign alert_push = btn_state == power_supervisor_pkg::BTN_EXTRA && power_state;

    // ****************************************
    // Mode pin commands
    // ****************************************
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            select_b_prev <= 1'b1;
        end else begin
            select_b_prev <= pins.select_b;
        end
    end

    // Both mode pins high is button-only mode, so edges of select_b count only while select_a high alone
    // cannot be told apart; select_b tied to select_a never toggles, so edges stay harmless there
    assign digital_on = pins.select_a && pins.select_b && !select_b_prev;
    assign digital_off = pins.select_a && !pins.select_b && select_b_prev;

    // ****************************************
    // On/off state and shutdown sequence
    // ****************************************
    logic [`COUNT_WIDTH-1:0] blank_count;
    logic blanking;
    logic kill_off;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            power_state <= 1'b0;
        end else if (push_on || (digital_on && !power_state)) begin
            power_state <= 1'b1;
        end else if (push_off || (digital_off && power_state) || kill_off) begin
            power_state <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_shutdown <= 1'b0;
            shut_count <= '0;
        end else if (power_state && (push_off || digital_off || kill_off)) begin
            in_shutdown <= 1'b1;
            shut_count <= '0;
        end else if (in_shutdown) begin
            if (reached(shut_count, SHUTDOWN_CYCLES)) begin
                in_shutdown <= 1'b0;
            end else begin
                shut_count <= shut_count + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            blanking <= 1'b0;
            blank_count <= '0;
        end else if (push_on || (digital_on && !power_state)) begin
            blanking <= 1'b1;
            blank_count <= '0;
        end else if (!power_state) begin
            blanking <= 1'b0;
            blank_count <= '0;
        end else if (blanking) begin
            if (reached(blank_count, BLANKING_CYCLES)) begin
                blanking <= 1'b0;
            end else begin
                blank_count <= blank_count + 1'b1;
            end
        end
    end

    assign kill_off = power_state && !blanking && !pins.kill_n && !in_shutdown;

    // ****************************************
    // Outputs
    // ****************************************
    logic powered;

    assign powered = power_state || in_shutdown;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_diode_primary_en <= 1'b0;
            o_diode_secondary_en <= 1'b0;
            o_converter_en_oe <= 1'b1;
            o_power_on <= 1'b0;
        end else begin
            o_diode_primary_en <= powered;
            o_diode_secondary_en <= powered;
            o_converter_en_oe <= !powered;
            o_power_on <= power_state;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_host_alert_n_oe <= 1'b0;
            o_early_warn_out_n_oe <= 1'b0;
        end else begin
            o_host_alert_n_oe <= alert_push || in_shutdown;
            o_early_warn_out_n_oe <= !pins.early_warn_in;
        end
    end

    reset_watchdog #(
        .RESET_CYCLES(RESET_CYCLES),
        .WATCHDOG_CYCLES(WATCHDOG_CYCLES)
    ) u_reset_watchdog (
        .i_sys_clk(i_sys_clk),
        .i_reset_n(i_reset_n),
        .i_supply_sense(pins.supply_sense),
        .i_heartbeat_in(pins.heartbeat_in),
        .i_heartbeat_float(pins.heartbeat_float),
        .o_sys_reset_n(sys_reset_n)
    );

    assign o_sys_reset_n_oe = !sys_reset_n;

endmodule : pushbutton_power_supervisor

// file: testbench/pushbutton_power_supervisor_asserts.sv
// Port-level checker for the pushbutton power supervisor.
// Assumes the bind below passes the instance counts on.
`include "power_supervisor_defs.svh"
module pbps_checker #(
    parameter int DEBOUNCE_CYCLES = 20,
    parameter int RESET_CYCLES = 30,
    parameter int WATCHDOG_CYCLES = 60
) (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_button_in_n,
    input wire logic i_supply_sense,
    input wire logic i_heartbeat_in,
    input wire logic i_heartbeat_float,
    input wire logic i_early_warn_in,
    input wire logic [`EXTRA_WIDTH-1:0] i_turn_on_extra_delay,
    input wire logic o_diode_primary_en,
    input wire logic o_diode_secondary_en,
    input wire logic o_converter_en_oe,
    input wire logic o_host_alert_n_oe,
    input wire logic o_early_warn_out_n_oe,
    input wire logic o_sys_reset_n_oe,
    input wire logic o_power_on
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Helper counters
    // ****************
    int sup_cnt;
    int hb_idle;
    int btn_cnt;
    logic hb_q;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n || !i_supply_sense)
            sup_cnt <= 0;
        else
            sup_cnt <= sup_cnt + 1;
    end
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hb_q <= 1'b0;
            hb_idle <= 0;
        end else begin
            hb_q <= i_heartbeat_in;
            if (i_heartbeat_in != hb_q || o_sys_reset_n_oe || i_heartbeat_float)
                hb_idle <= 0;
            else
                hb_idle <= hb_idle + 1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n || i_button_in_n)
            btn_cnt <= 0;
        else
            btn_cnt <= btn_cnt + 1;
    end
    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_shut_hold;
        (o_host_alert_n_oe && o_diode_primary_en)[*8];
    endsequence
    sequence s_off_done;
        !o_diode_primary_en && o_converter_en_oe && !o_host_alert_n_oe;
    endsequence
    a_warn_high: assert property (i_early_warn_in[*8] |-> !o_early_warn_out_n_oe)
        else $error("power-fail pulled while input high");
    a_warn_low: assert property (!i_early_warn_in[*8] |-> o_early_warn_out_n_oe)
        else $error("power-fail released while input low");
    a_rst_supply_low: assert property (!i_supply_sense[*6] |-> o_sys_reset_n_oe)
        else $error("reset released with supply low");
    a_rst_hold_min: assert property ($fell(o_sys_reset_n_oe) |-> sup_cnt >= RESET_CYCLES)
        else $error("reset released too early");
    a_rst_release: assert property (sup_cnt == RESET_CYCLES + 10 |-> !o_sys_reset_n_oe)
        else $error("reset held too long");
    a_wdog_expire: assert property ($rose(o_sys_reset_n_oe) && sup_cnt > RESET_CYCLES + 10
        |-> hb_idle >= WATCHDOG_CYCLES) else $error("watchdog expired early");
    a_wdog_late: assert property (hb_idle == WATCHDOG_CYCLES + 8 && sup_cnt > RESET_CYCLES + 10
        |-> o_sys_reset_n_oe) else $error("watchdog did not expire");
    a_on_enables: assert property ($rose(o_power_on)
        |=> o_diode_primary_en && o_diode_secondary_en && !o_converter_en_oe) else $error("turn-on outputs wrong");
    a_push_debounce: assert property ($rose(o_power_on) && !i_button_in_n
        |-> btn_cnt >= DEBOUNCE_CYCLES + i_turn_on_extra_delay) else $error("push accepted too early");
    a_alert_fixed: assert property ($rose(o_host_alert_n_oe) && o_power_on && !i_button_in_n
        |-> btn_cnt inside {[DEBOUNCE_CYCLES:DEBOUNCE_CYCLES + 8]}) else $error("alert timing wrong");
    a_alert_free: assert property ((o_host_alert_n_oe && o_power_on) ##0 i_button_in_n[*8]
        |-> !o_host_alert_n_oe || !o_power_on) else $error("alert not freed on release");
    a_shut_seq: assert property ($fell(o_power_on) |=> s_shut_hold ##[1:1000] s_off_done)
        else $error("shutdown sequence wrong");
endmodule : pbps_checker

bind pushbutton_power_supervisor pbps_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .RESET_CYCLES(RESET_CYCLES),
    .WATCHDOG_CYCLES(WATCHDOG_CYCLES)) chk_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_button_in_n(i_button_in_n), .i_supply_sense(i_supply_sense), .i_heartbeat_in(i_heartbeat_in),
    .i_heartbeat_float(i_heartbeat_float), .i_early_warn_in(i_early_warn_in),
    .i_turn_on_extra_delay(i_turn_on_extra_delay), .o_diode_primary_en(o_diode_primary_en),
    .o_diode_secondary_en(o_diode_secondary_en), .o_converter_en_oe(o_converter_en_oe),
    .o_host_alert_n_oe(o_host_alert_n_oe), .o_early_warn_out_n_oe(o_early_warn_out_n_oe),
    .o_sys_reset_n_oe(o_sys_reset_n_oe), .o_power_on(o_power_on));

// file: testbench/host_partner_model.sv
// Host processor and converter stand-in on the far side of the supervisor.
// Assumes the bench sets heartbeat pacing and whether the host ends kill.
module host_partner_model (
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    input wire logic i_converter_en_oe,
    input wire logic i_hb_run,
    input wire logic [7:0] i_hb_period,
    input wire logic i_kill_ok,
    output logic o_heartbeat_in,
    output logic o_kill_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int hb_cnt;
    int up_cnt;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hb_cnt <= 0;
            o_heartbeat_in <= 1'b0;
        end else if (i_hb_run && hb_cnt >= int'(i_hb_period)) begin
            hb_cnt <= 0;
            o_heartbeat_in <= !o_heartbeat_in;
        end else begin
            hb_cnt <= hb_cnt + 1;
        end
    end
    // Kill stays low until the rail has been up for a while
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n || i_converter_en_oe) begin
            up_cnt <= 0;
            o_kill_n <= 1'b0;
        end else begin
            up_cnt <= up_cnt + 1;
            if (i_kill_ok && up_cnt == 10)
                o_kill_n <= 1'b1;
        end
    end
endmodule : host_partner_model

// file: testbench/pushbutton_power_supervisor_tb_top.sv
// Self-checking bench for the pushbutton power supervisor.
// Assumes shortened counts; inputs change 1 ns after the rising edge.
`include "power_supervisor_defs.svh"
module pushbutton_power_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 20;
    localparam int RST = 30;
    localparam int WD = 60;
    localparam int BLK = 40;
    localparam int SD = 10;
    localparam int ON_X = 6;
    localparam int OFF_X = 12;
    logic i_sys_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic button_n, select_a, select_b, supply_sense, heartbeat_float, early_warn_in, hb_run, kill_ok;
    logic heartbeat_in, kill_n, diode_pri, diode_sec, conv_oe, alert_oe, warn_oe, rst_oe, power_on;
    logic [7:0] hb_period;
    logic [`EXTRA_WIDTH-1:0] on_extra = ON_X;
    logic [`EXTRA_WIDTH-1:0] off_extra = OFF_X;
    logic [31:0] rng = 32'h0000_0019;
    int num_errors = 0;
    int n_checks = 0;
    always #5 i_sys_clk = !i_sys_clk;
    pushbutton_power_supervisor #(.DEBOUNCE_CYCLES(DEB), .RESET_CYCLES(RST), .WATCHDOG_CYCLES(WD),
        .BLANKING_CYCLES(BLK), .SHUTDOWN_CYCLES(SD)) dut_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
        .i_button_in_n(button_n), .i_select_a(select_a), .i_select_b(select_b), .i_supply_sense(supply_sense),
        .i_heartbeat_in(heartbeat_in), .i_heartbeat_float(heartbeat_float), .i_early_warn_in(early_warn_in),
        .i_kill_n(kill_n), .i_turn_on_extra_delay(on_extra), .i_shutdown_extra_delay(off_extra),
        .o_diode_primary_en(diode_pri), .o_diode_secondary_en(diode_sec), .o_converter_en_oe(conv_oe),
        .o_host_alert_n_oe(alert_oe), .o_early_warn_out_n_oe(warn_oe), .o_sys_reset_n_oe(rst_oe),
        .o_power_on(power_on));
    host_partner_model host_u (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_converter_en_oe(conv_oe),
        .i_hb_run(hb_run), .i_hb_period(hb_period), .i_kill_ok(kill_ok), .o_heartbeat_in(heartbeat_in),
        .o_kill_n(kill_n));
    // ****************
    // Helpers
    // ****************
    function automatic logic [31:0] next_rand();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : next_rand
    function automatic logic exp_warn(input logic v);
        return !v;
    endfunction : exp_warn
    function automatic logic pick(input int k);
        case (k)
            0: return power_on;
            1: return diode_pri;
            2: return alert_oe;
            3: return rst_oe;
            default: return conv_oe;
        endcase
    endfunction : pick
    task automatic tick(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : tick
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            num_errors++;
            $display("[ERR] %0t wait ran out", $time);
            wrap_up();
        end
    endtask : wait_for
    task automatic press();
        repeat (3) begin
            button_n = 1'b0;
            tick(1 + next_rand() % 8);
            button_n = 1'b1;
            tick(2 + next_rand() % 4);
        end
        button_n = 1'b0;
    endtask : press
    // ****************
    // Scenarios
    // ****************
    initial begin
        int n;
        logic [31:0] v;
        {button_n, select_a, select_b, supply_sense, early_warn_in, hb_run, kill_ok} = 7'h7F;
        heartbeat_float = 1'b0;
        hb_period = 8'h14;
        tick(5);
        i_reset_n = 1'b1;
        tick(40);
        press();
        wait_for(0, 1'b1, DEB + ON_X + 20, n);
        chk(n >= DEB + ON_X, 1'b1, "turn-on too early");
        tick(2);
        chk(diode_sec, 1'b1, "secondary diode off");
        chk(conv_oe, 1'b0, "converter held off");
        button_n = 1'b1;
        tick(5);
        button_n = 1'b0;
        tick(DEB + OFF_X + 15);
        chk(power_on, 1'b1, "push inside release window taken");
        button_n = 1'b1;
        tick(40);
        button_n = 1'b0;
        tick(DEB + 8);
        chk(alert_oe, 1'b1, "alert not raised");
        button_n = 1'b1;
        tick(8);
        chk(alert_oe, 1'b0, "alert not freed");
        chk(power_on, 1'b1, "short push turned off");
        tick(40);
        button_n = 1'b0;
        wait_for(0, 1'b0, DEB + OFF_X + 20, n);
        chk(alert_oe, 1'b1, "alert dropped at shutdown");
        chk(diode_pri, 1'b1, "diodes cut before shutdown");
        wait_for(1, 1'b0, SD + 10, n);
        chk(conv_oe, 1'b1, "converter not disabled");
        button_n = 1'b1;
        select_b = 1'b0;
        tick(10);
        chk(power_on, 1'b0, "off command while off acted");
        select_b = 1'b1;
        wait_for(0, 1'b1, 10, n);
        tick(BLK + 20);
        chk(conv_oe, 1'b0, "digital on lost");
        select_b = 1'b0;
        wait_for(0, 1'b0, 10, n);
        tick(2);
        chk(alert_oe, 1'b1, "no alert on digital off");
        wait_for(1, 1'b0, SD + 10, n);
        chk(conv_oe, 1'b1, "converter on after digital off");
        kill_ok = 1'b0;
        select_b = 1'b1;
        wait_for(0, 1'b1, 10, n);
        wait_for(0, 1'b0, BLK + 20, n);
        chk(n inside {[BLK - 2:BLK + 4]}, 1'b1, "kill blanking wrong");
        wait_for(4, 1'b1, SD + 10, n);
        kill_ok = 1'b1;
        repeat (8) begin
            v = next_rand();
            early_warn_in = v[0];
            tick(9);
            chk(warn_oe, exp_warn(early_warn_in), "power-fail output wrong");
        end
        supply_sense = 1'b0;
        tick(8);
        chk(rst_oe, 1'b1, "reset free with supply low");
        supply_sense = 1'b1;
        tick(RST - 2);
        chk(rst_oe, 1'b1, "reset freed early");
        v = next_rand();
        hb_period = 8'h0A + 8'(v[4:0]);
        tick(12);
        chk(rst_oe, 1'b0, "reset held long");
        tick(200);
        chk(rst_oe, 1'b0, "watchdog fired with heartbeat");
        hb_run = 1'b0;
        wait_for(3, 1'b1, WD + 20, n);
        wait_for(3, 1'b0, RST + 10, n);
        chk(n inside {[RST - 2:RST + 2]}, 1'b1, "pulse length wrong");
        wait_for(3, 1'b1, WD + 10, n);
        chk(n inside {[WD - 2:WD + 2]}, 1'b1, "release length wrong");
        heartbeat_float = 1'b1;
        wait_for(3, 1'b0, RST + 10, n);
        tick(200);
        chk(rst_oe, 1'b0, "watchdog ran while floating");
        wrap_up();
    end
endmodule : pushbutton_power_supervisor_tb_top
